// File: rtl/rtc_evt_pkg.sv
package rtc_evt_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h0E;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h10;
  localparam logic [7:0] ADDR_CLK_MASK = 8'h12;
  localparam logic [7:0] ADDR_EVT_CTRL = 8'h13;
  localparam logic [7:0] ADDR_TS_COUNT = 8'h14;
  localparam logic [7:0] ADDR_TS_SEC = 8'h15;
  localparam logic [7:0] ADDR_TS_MIN = 8'h16;
  localparam logic [7:0] ADDR_TS_HOUR = 8'h17;
  localparam logic [7:0] ADDR_TS_DATE = 8'h18;
  localparam logic [7:0] ADDR_TS_MONTH = 8'h19;
  localparam logic [7:0] ADDR_TS_YEAR = 8'h1A;
  localparam logic [7:0] ADDR_NV_CLKOUT = 8'h35;
  localparam logic [7:0] ADDR_NV_BACKUP = 8'h37;
  // Status field positions
  localparam int ST_POWERUP = 0;
  localparam int ST_EVENT = 1;
  localparam int ST_SWITCH = 5;
  // Control two field positions
  localparam int C2_EVT_IRQ = 2;
  localparam int C2_STAMP_EN = 7;
  // Clock interrupt mask field position
  localparam int CM_EVT_CLK = 3;
  // Event control field positions
  localparam int EC_SRC = 0;
  localparam int EC_OVERWRITE = 1;
  localparam int EC_CLEAR = 2;
  localparam int EC_TYPE_LO = 4;
  localparam int EC_POLARITY = 6;
  // Clock-out config field positions
  localparam int NC_FREQ_LO = 0;
  localparam int NC_POR_IRQ = 3;
  localparam int NC_CLK_PATH = 6;
  localparam int NC_FORCE = 7;
  // Backup config field positions
  localparam int NB_MODE_LO = 2;
  localparam int NB_SW_IRQ = 5;
  localparam int NB_FAST_EDGE = 6;
  // Field codes and reset values
  localparam logic [1:0] TYPE_EDGE = 2'h0;
  localparam logic [1:0] MODE_DIRECT = 2'h1;
  localparam logic [1:0] MODE_LEVEL = 2'h3;
  localparam logic [2:0] FREQ_OFF = 3'h7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_NV_CLKOUT = 8'h00;
  localparam logic [7:0] RST_NV_BACKUP = 8'h40;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  // Timing
  localparam int MCLK_PERIOD_NS = 25;
  localparam int DEBOUNCE_MIN_NS = 122000;
  localparam int DEBOUNCE_MAX_NS = 183000;
  // Serial slave states
  typedef enum logic [3:0] {
    SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_PTR, SL_PTR_ACK, SL_WR, SL_WR_ACK, SL_RD, SL_RD_ACK
  } slave_state_e;
  // Calendar snapshot carried as one bundle
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } calendar_s;
endpackage

// File: rtl/rtc_event_stamp_irq.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_event_stamp_irq
  import rtc_evt_pkg::*;
#(
  parameter logic [6:0] SlaveAddr = 7'h50,
  parameter int DebCycles = (DEBOUNCE_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS,
  parameter int FiltCycles = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic eventClk,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaDriveN,
  input wire logic eventInputPin,
  input wire logic onBackupPin,
  input wire logic porDetectPin,
  input wire calendar_s calendar,
  output logic intN,
  output logic clkOutEn,
  output logic [2:0] clkOutFreq
);
  // Refuse counts the counters cannot hold
  if (DebCycles < 1 || DebCycles > 65535 || FiltCycles < 1 || FiltCycles > 65535) begin : gBad
    $error("rtc_event_stamp_irq: count parameter out of range");
  end

  // ---------------- Event pin side, on the event clock ----------------
  logic evS1_q, evS2_q; // Pin synchroniser
  logic [2:0] cfgS1_q, cfgS2_q; // Polarity and type, quasi-static levels
  logic prevAct_q; // Last active state for edges
  logic [15:0] filtCnt_q; // Level filter run length
  logic evTog_q; // Toggles once per detected event
  logic cfgPol; // Polarity from the register file
  logic [1:0] cfgType; // Detection type from the register file
  wire logic pinAct = cfgS2_q[2] ? evS2_q : ~evS2_q;
  wire logic edgeMode = cfgS2_q[1:0] == TYPE_EDGE;
  wire logic filtDone = filtCnt_q == 16'(FiltCycles - 1);
  wire logic pinFire = edgeMode ? (pinAct & ~prevAct_q) : (pinAct & filtDone);

  // Synchronise pin and settings into the event clock
  always_ff @(posedge eventClk or negedge rst_n) begin
    if (!rst_n) begin
      evS1_q <= 1'b0;
      evS2_q <= 1'b0;
      cfgS1_q <= 3'h0;
      cfgS2_q <= 3'h0;
    end else begin
      evS1_q <= eventInputPin;
      evS2_q <= evS1_q;
      cfgS1_q <= {cfgPol, cfgType};
      cfgS2_q <= cfgS1_q;
    end
  end

  // Edge memory, level filter and event toggle
  always_ff @(posedge eventClk or negedge rst_n) begin
    if (!rst_n) begin
      prevAct_q <= 1'b1; // Seen as active, so no false edge follows reset
      filtCnt_q <= 16'h0000;
      evTog_q <= 1'b0;
    end else begin
      prevAct_q <= pinAct;
      // Counter stops past the threshold so a held level fires once
      if (!pinAct) filtCnt_q <= 16'h0000;
      else if (filtCnt_q != 16'(FiltCycles)) filtCnt_q <= filtCnt_q + 16'h0001;
      if (pinFire) evTog_q <= ~evTog_q;
    end
  end

  // ---------------- Control side, on mclk ----------------
  logic tgS1_q, tgS2_q, tgS3_q; // Event toggle crossing
  logic pmS1_q, pmS2_q; // Pin level for the source-swap case
  logic bkS1_q, bkS2_q, bkS3_q; // Supply state
  logic prS1_q, prS2_q, prS3_q; // Supply-loss detector
  logic sclS1_q, sclS2_q, sclS3_q; // Serial clock
  logic sdaS1_q, sdaS2_q, sdaS3_q; // Serial data

  // Two-stage synchronisers, third stage for edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {tgS1_q, tgS2_q, tgS3_q} <= 3'h0;
      {pmS1_q, pmS2_q} <= 2'h0;
      {bkS1_q, bkS2_q, bkS3_q} <= 3'h0;
      {prS1_q, prS2_q, prS3_q} <= 3'h0;
      {sclS1_q, sclS2_q, sclS3_q} <= 3'h7;
      {sdaS1_q, sdaS2_q, sdaS3_q} <= 3'h7;
    end else begin
      {tgS1_q, tgS2_q, tgS3_q} <= {evTog_q, tgS1_q, tgS2_q};
      {pmS1_q, pmS2_q} <= {eventInputPin, pmS1_q};
      {bkS1_q, bkS2_q, bkS3_q} <= {onBackupPin, bkS1_q, bkS2_q};
      {prS1_q, prS2_q, prS3_q} <= {porDetectPin, prS1_q, prS2_q};
      {sclS1_q, sclS2_q, sclS3_q} <= {sclPin, sclS1_q, sclS2_q};
      {sdaS1_q, sdaS2_q, sdaS3_q} <= {sdaPin, sdaS1_q, sdaS2_q};
    end
  end

  // Register file
  logic [7:0] ctrlTwo_q, clkMask_q, evtCtrl_q, nvClk_q, nvBak_q;
  logic evtFlag_q, swFlag_q, porFlag_q; // Sticky flags
  logic [7:0] tsCount_q; // Event counter
  calendar_s tsCal_q; // Captured time
  logic srcPrev_q; // Source select one cycle ago
  logic autoClk_q; // Clock output requested by an event
  logic [15:0] debCnt_q; // Debounce remaining
  logic regWr; // One-cycle write strobe from the slave
  logic [7:0] regAddr, regWdata, regRdata;
  logic tsBlock;

  // Field decode
  wire logic stampEn = ctrlTwo_q[C2_STAMP_EN];
  wire logic evtIrqEn = ctrlTwo_q[C2_EVT_IRQ];
  wire logic srcSel = evtCtrl_q[EC_SRC];
  wire logic overwrite = evtCtrl_q[EC_OVERWRITE];
  wire logic [1:0] swMode = nvBak_q[NB_MODE_LO +: 2];
  wire logic [2:0] freqSel = nvClk_q[NC_FREQ_LO +: 3];
  assign cfgPol = evtCtrl_q[EC_POLARITY];
  assign cfgType = evtCtrl_q[EC_TYPE_LO +: 2];

  // Event sources
  wire logic extEvt = tgS2_q ^ tgS3_q;
  wire logic modeOk = swMode == MODE_DIRECT || swMode == MODE_LEVEL;
  wire logic swEvt = bkS2_q & ~bkS3_q & modeOk;
  wire logic supplyBack = ~bkS2_q & bkS3_q;
  wire logic enAny = stampEn | evtIrqEn;
  wire logic pinActM = cfgPol ? pmS2_q : ~pmS2_q;
  wire logic swapEvt = srcPrev_q & ~srcSel & enAny & pinActM;
  wire logic srcEvt = srcSel ? swEvt : (extEvt | swapEvt);
  wire logic evtFlagSet = srcEvt & enAny;
  wire logic wrStatus = regWr && regAddr == ADDR_STATUS;
  wire logic stampClr = regWr && regAddr == ADDR_EVT_CTRL && regWdata[EC_CLEAR];
  wire logic capture = srcEvt & stampEn & (overwrite | ~evtFlag_q) & ~tsBlock & ~stampClr;
  wire logic countInc = srcEvt & stampEn & ~stampClr & (tsCount_q != COUNT_MAX);
  wire logic evtIrqInt = evtIrqEn & (srcSel ? (swEvt & stampEn) : srcEvt);
  wire logic porSet = prS2_q & ~prS3_q;
  wire logic irqAny = (evtFlag_q & evtIrqEn) | (swFlag_q & nvBak_q[NB_SW_IRQ])
                    | (porFlag_q & nvClk_q[NC_POR_IRQ]);
  wire logic clkOnNext = nvClk_q[NC_FORCE] | (nvClk_q[NC_CLK_PATH] & autoClk_q
                    & freqSel != FREQ_OFF & ~bkS2_q & ~bkS3_q & debCnt_q == 16'h0000);

  // Writable configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlTwo_q <= RST_ZERO;
      clkMask_q <= RST_ZERO;
      evtCtrl_q <= RST_ZERO;
      nvClk_q <= RST_NV_CLKOUT;
      nvBak_q <= RST_NV_BACKUP;
      srcPrev_q <= 1'b0;
    end else begin
      srcPrev_q <= srcSel;
      if (regWr && regAddr == ADDR_CTRL_TWO) ctrlTwo_q <= regWdata;
      if (regWr && regAddr == ADDR_CLK_MASK) clkMask_q <= regWdata;
      // Clear bit is a command and is never stored
      if (regWr && regAddr == ADDR_EVT_CTRL) evtCtrl_q <= regWdata & ~(8'h01 << EC_CLEAR);
      if (regWr && regAddr == ADDR_NV_CLKOUT) nvClk_q <= regWdata;
      if (regWr && regAddr == ADDR_NV_BACKUP) nvBak_q <= regWdata;
    end
  end

  // Sticky flags: a written zero clears, a set in the same cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evtFlag_q <= 1'b0;
      swFlag_q <= 1'b0;
      porFlag_q <= 1'b1; // Time is invalid after a cold start
    end else begin
      evtFlag_q <= (evtFlag_q & ~(wrStatus & ~regWdata[ST_EVENT])) | evtFlagSet;
      swFlag_q <= (swFlag_q & ~(wrStatus & ~regWdata[ST_SWITCH])) | swEvt;
      porFlag_q <= (porFlag_q & ~(wrStatus & ~regWdata[ST_POWERUP])) | porSet;
    end
  end

  // Stamp registers and counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tsCount_q <= RST_ZERO;
      tsCal_q <= '0;
    end else if (stampClr) begin
      tsCount_q <= RST_ZERO;
      tsCal_q <= '0;
    end else begin
      if (countInc) tsCount_q <= tsCount_q + 8'h01;
      if (capture) tsCal_q <= calendar;
    end
  end

  // Debounce after supply return, then pin outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      debCnt_q <= 16'h0000;
      autoClk_q <= 1'b0;
      intN <= 1'b1;
      clkOutEn <= 1'b0;
      clkOutFreq <= FREQ_OFF;
    end else begin
      if (supplyBack) debCnt_q <= 16'(DebCycles);
      else if (debCnt_q != 16'h0000) debCnt_q <= debCnt_q - 16'h0001;
      // Auto request drops when the event flag has been cleared
      autoClk_q <= (autoClk_q & evtFlag_q) | (evtIrqInt & clkMask_q[CM_EVT_CLK]);
      intN <= ~irqAny;
      clkOutEn <= clkOnNext;
      clkOutFreq <= freqSel;
    end
  end

  // ---------------- Serial register slave ----------------
  slave_state_e st_q;
  logic [7:0] shift_q, ptr_q;
  logic [3:0] bitCnt_q;
  logic rdMode_q, ackRx_q;
  wire logic sclRise = sclS2_q & ~sclS3_q;
  wire logic sclFall = ~sclS2_q & sclS3_q;
  wire logic startCond = sclS2_q & ~sdaS2_q & sdaS3_q;
  wire logic stopCond = sclS2_q & sdaS2_q & ~sdaS3_q;
  wire logic addrHit = shift_q[7:1] == SlaveAddr && debCnt_q == 16'h0000;
  assign tsBlock = (st_q == SL_RD || st_q == SL_RD_ACK) && ptr_q >= ADDR_TS_COUNT
                   && ptr_q <= ADDR_TS_YEAR;
  assign regAddr = ptr_q;
  assign regWdata = shift_q;
  assign regWr = sclFall && st_q == SL_WR && bitCnt_q == 4'h8;

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (ptr_q)
      ADDR_STATUS: regRdata = (8'(swFlag_q) << ST_SWITCH) | (8'(evtFlag_q) << ST_EVENT)
                              | (8'(porFlag_q) << ST_POWERUP);
      ADDR_CTRL_TWO: regRdata = ctrlTwo_q;
      ADDR_CLK_MASK: regRdata = clkMask_q;
      ADDR_EVT_CTRL: regRdata = evtCtrl_q;
      ADDR_TS_COUNT: regRdata = tsCount_q;
      ADDR_TS_SEC: regRdata = tsCal_q.seconds;
      ADDR_TS_MIN: regRdata = tsCal_q.minutes;
      ADDR_TS_HOUR: regRdata = tsCal_q.hours;
      ADDR_TS_DATE: regRdata = tsCal_q.date;
      ADDR_TS_MONTH: regRdata = tsCal_q.month;
      ADDR_TS_YEAR: regRdata = tsCal_q.year;
      ADDR_NV_CLKOUT: regRdata = nvClk_q;
      ADDR_NV_BACKUP: regRdata = nvBak_q;
      default: regRdata = RST_ZERO;
    endcase
  end

  // Byte framing, acknowledge and pointer handling
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SL_IDLE;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      bitCnt_q <= 4'h0;
      rdMode_q <= 1'b0;
      ackRx_q <= 1'b0;
      sdaDriveN <= 1'b1;
      sdaOut <= 1'b0;
    end else if (startCond) begin
      st_q <= SL_ADDR;
      bitCnt_q <= 4'h0;
      sdaDriveN <= 1'b1;
    end else if (stopCond) begin
      st_q <= SL_IDLE;
      sdaDriveN <= 1'b1;
    end else if (sclRise) begin
      // Sample incoming bits and the master acknowledge
      if (st_q == SL_ADDR || st_q == SL_PTR || st_q == SL_WR) begin
        shift_q <= {shift_q[6:0], sdaS2_q};
        bitCnt_q <= bitCnt_q + 4'h1;
      end
      if (st_q == SL_RD_ACK) ackRx_q <= ~sdaS2_q;
    end else if (sclFall) begin
      case (st_q)
        SL_ADDR: if (bitCnt_q == 4'h8) begin
          st_q <= addrHit ? SL_ADDR_ACK : SL_IDLE;
          sdaDriveN <= ~addrHit;
          rdMode_q <= shift_q[0];
        end
        SL_ADDR_ACK: begin
          bitCnt_q <= 4'h0;
          st_q <= rdMode_q ? SL_RD : SL_PTR;
          shift_q <= regRdata;
          sdaDriveN <= rdMode_q ? regRdata[7] : 1'b1;
        end
        SL_PTR: if (bitCnt_q == 4'h8) begin
          st_q <= SL_PTR_ACK;
          ptr_q <= shift_q;
          sdaDriveN <= 1'b0;
        end
        SL_WR: if (bitCnt_q == 4'h8) begin
          st_q <= SL_WR_ACK;
          ptr_q <= ptr_q + 8'h01;
          sdaDriveN <= 1'b0;
        end
        SL_PTR_ACK, SL_WR_ACK: begin
          st_q <= SL_WR;
          bitCnt_q <= 4'h0;
          sdaDriveN <= 1'b1;
        end
        SL_RD: if (bitCnt_q == 4'h7) begin
          st_q <= SL_RD_ACK;
          ptr_q <= ptr_q + 8'h01;
          sdaDriveN <= 1'b1;
        end else begin
          shift_q <= {shift_q[6:0], 1'b0};
          bitCnt_q <= bitCnt_q + 4'h1;
          sdaDriveN <= shift_q[6];
        end
        SL_RD_ACK: begin
          // Master not acknowledging ends the read
          st_q <= ackRx_q ? SL_RD : SL_IDLE;
          bitCnt_q <= 4'h0;
          shift_q <= regRdata;
          sdaDriveN <= ackRx_q ? regRdata[7] : 1'b1;
        end
        default: st_q <= SL_IDLE;
      endcase
    end
  end

  // ---------------- Assertions ----------------
  sequence clearWrite;
    regWr && regAddr == ADDR_EVT_CTRL && regWdata[EC_CLEAR];
  endsequence
  sequence supplyReturn;
    bkS3_q && !bkS2_q;
  endsequence

  stamp_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clearWrite |=> tsCount_q == RST_ZERO && tsCal_q == '0 && !evtCtrl_q[EC_CLEAR])
    else $error("stamp clear did not zero stamps");
  count_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    srcEvt && stampEn && !stampClr && tsCount_q != COUNT_MAX
      |=> tsCount_q == $past(tsCount_q) + 8'h01)
    else $error("event counter missed an event");
  first_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
    srcEvt && !overwrite && evtFlag_q && !stampClr |=> $stable(tsCal_q))
    else $error("stamp overwritten without overwrite");
  recapture_a: assert property (@(posedge mclk) disable iff (!rst_n)
    srcEvt && stampEn && overwrite && !tsBlock && !stampClr |=> tsCal_q == $past(calendar))
    else $error("stamp not recaptured");
  read_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tsBlock && !stampClr |=> $stable(tsCal_q))
    else $error("stamp changed during stamp read");
  int_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 intN == !$past(irqAny))
    else $error("interrupt pin does not follow enabled flags");
  por_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    porSet && nvClk_q[NC_POR_IRQ] |=> porFlag_q ##1 !intN)
    else $error("supply loss not flagged");
  flag_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wrStatus && regWdata[ST_EVENT] && evtFlag_q |=> evtFlag_q)
    else $error("writing one cleared a flag");
  sw_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    bkS2_q && !bkS3_q && !modeOk && !swFlag_q && !wrStatus |=> !swFlag_q)
    else $error("switchover flagged in off mode");
  debounce_a: assert property (@(posedge mclk) disable iff (!rst_n)
    supplyReturn ##0 !nvClk_q[NC_FORCE] |=> debCnt_q == 16'(DebCycles) && !clkOutEn
      ##1 !clkOutEn)
    else $error("access or clock not held off after supply return");
  src_swap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    srcPrev_q && !srcSel && enAny && pinActM |=> evtFlag_q)
    else $error("source swap event lost");
endmodule
`default_nettype wire

// File: verif/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the serial register port; data is open drain, so it only ever pulls data low, clock is driven both ways
module i2c_host_model (
  input wire logic mclk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaLow
);
  // Idle bus: clock driven high, data released to the pull-up
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  // Third of a bit, long against the pin synchronisers of the slave
  task automatic tick();
    repeat (6) @(negedge mclk);
  endtask
  // Start or repeated start, entered from idle or clock-low
  task automatic busStart();
    sdaLow = 1'b0;
    tick();
    sclOut = 1'b1;
    tick();
    sdaLow = 1'b1;
    tick();
    sclOut = 1'b0;
    tick();
  endtask
  // Stop: data rises while clock is high
  task automatic busStop();
    sdaLow = 1'b1;
    tick();
    sclOut = 1'b1;
    tick();
    sdaLow = 1'b0;
    tick();
  endtask
  // One bit: data changes only while clock low, sampled while high
  task automatic bitIo(input logic b, output logic r);
    sdaLow = ~b;
    tick();
    sclOut = 1'b1;
    tick();
    r = sdaWire;
    sclOut = 1'b0;
    tick();
  endtask
  // One byte, most significant bit first
  task automatic byteIo(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], r[i]);
    end
  endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtc_evt_pkg::*;
  localparam logic [6:0] Slv = 7'h50; // Slave address used on the bus
  localparam int DebSim = 400; // Shortened debounce count
  logic mclk, rst_n, eventClk, evtPin, backup, porPin; // Bench-driven inputs
  logic scl, hostLow, sdaWire, sdaOut, sdaDriveN; // Serial bus lines
  logic intN, clkOutEn; // Device outputs
  logic [2:0] clkOutFreq; // Selected output frequency
  calendar_s cal, oldCal; // Live time fed to the device
  int errors, check_count; // Mismatch and comparison counts
  logic lastAck; // Acknowledge bit of the last byte sent
  logic [7:0] junk; // Discarded read-back
  logic [7:0] rdBuf [0:6]; // Burst read results

  // Open-drain wire with pull-up
  assign sdaWire = ~hostLow & (sdaDriveN | sdaOut);

  rtc_event_stamp_irq #(.SlaveAddr(Slv), .DebCycles(DebSim), .FiltCycles(2)) dut (
    .mclk(mclk), .rst_n(rst_n), .eventClk(eventClk), .sclPin(scl), .sdaPin(sdaWire),
    .sdaOut(sdaOut), .sdaDriveN(sdaDriveN), .eventInputPin(evtPin), .onBackupPin(backup),
    .porDetectPin(porPin), .calendar(cal), .intN(intN), .clkOutEn(clkOutEn),
    .clkOutFreq(clkOutFreq));
  i2c_host_model h (.mclk(mclk), .sdaWire(sdaWire), .sclOut(scl), .sdaLow(hostLow));

  // Main clock and unrelated event-pin clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    eventClk = 1'b0;
    #7;
    forever #15 eventClk = ~eventClk;
  end

  // Byte comparison
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Single pin comparison
  task automatic chkBit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic waitClk(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Byte out, then the slave's acknowledge bit
  task automatic sendB(input logic [7:0] d);
    h.byteIo(d, junk);
    h.bitIo(1'b1, lastAck);
  endtask
  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    h.busStart();
    sendB({Slv, 1'b0});
    sendB(a);
    sendB(d);
    chkBit("writeAck", 1'b0, lastAck);
    h.busStop();
  endtask
  // Pointer write, repeated start, n bytes read, last one refused
  task automatic rdBurst(input logic [7:0] a, input int n);
    h.busStart();
    sendB({Slv, 1'b0});
    chkBit("addrAck", 1'b0, lastAck);
    sendB(a);
    h.busStart();
    sendB({Slv, 1'b1});
    for (int i = 0; i < n; i++) begin
      h.byteIo(8'hFF, rdBuf[i]);
      h.bitIo(i == n - 1, junk[0]);
    end
    h.busStop();
  endtask
  task automatic chkRd(input string name, input logic [7:0] a, input logic [7:0] exp);
    rdBurst(a, 1);
    chk8(name, exp, rdBuf[0]);
  endtask
  // Count and six captured calendar bytes in one burst
  task automatic chkStamps(input logic [7:0] cnt, input calendar_s c);
    rdBurst(ADDR_TS_COUNT, 7);
    chk8("stampCount", cnt, rdBuf[0]);
    for (int i = 1; i < 7; i++) begin
      chk8("stampByte", c[8*(i-1)+:8], rdBuf[i]);
    end
  endtask
  // Active-high pulse on the event pin
  task automatic pulse();
    evtPin = 1'b1;
    waitClk(40);
    evtPin = 1'b0;
    waitClk(40);
  endtask
  task automatic endTest(input string name);
    $display("test %s finished, %0d mismatches so far", name, errors);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    #2000000;
    errors++;
    $display("[FAIL] watchdog expected done seen hang");
    stop_test();
  end

  // Test sequence
  initial begin
    errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    evtPin = 1'b0;
    backup = 1'b0;
    porPin = 1'b0;
    cal = 48'h241231235958;
    waitClk(16);
    rst_n = 1'b1;
    waitClk(4);
    chkBit("intN", 1'b1, intN);
    chkRd("status", ADDR_STATUS, 8'h01);
    chkRd("backupCfg", ADDR_NV_BACKUP, RST_NV_BACKUP);
    chkRd("unmapped", 8'h20, 8'h00);
    endTest("reset");
    regWr(ADDR_NV_CLKOUT, 8'h0F);
    waitClk(4);
    chkBit("intN", 1'b0, intN);
    regWr(ADDR_STATUS, 8'h01);
    chkRd("status", ADDR_STATUS, 8'h01);
    regWr(ADDR_STATUS, 8'h00);
    waitClk(4);
    chkBit("intN", 1'b1, intN);
    porPin = 1'b1;
    waitClk(20);
    porPin = 1'b0;
    waitClk(10);
    chkBit("intN", 1'b0, intN);
    chkRd("status", ADDR_STATUS, 8'h01);
    regWr(ADDR_STATUS, 8'h00);
    regWr(ADDR_NV_CLKOUT, 8'h43);
    endTest("powerup");
    regWr(ADDR_CTRL_TWO, 8'h00);
    regWr(ADDR_EVT_CTRL, 8'h44);
    chkRd("eventCtrl", ADDR_EVT_CTRL, 8'h40);
    regWr(ADDR_CLK_MASK, 8'h08);
    regWr(ADDR_CTRL_TWO, 8'h84);
    pulse();
    chkBit("intN", 1'b0, intN);
    chkBit("clkOutEn", 1'b1, clkOutEn);
    chk8("clkOutFreq", 8'h03, {5'h00, clkOutFreq});
    chkStamps(8'h01, cal);
    oldCal = cal;
    cal = 48'h250101000001;
    pulse();
    chkStamps(8'h02, oldCal);
    regWr(ADDR_EVT_CTRL, 8'h52);
    pulse();
    chkStamps(8'h03, cal);
    regWr(ADDR_STATUS, 8'h02);
    chkRd("status", ADDR_STATUS, 8'h02);
    regWr(ADDR_STATUS, 8'h00);
    waitClk(4);
    chkBit("intN", 1'b1, intN);
    chkBit("clkOutEn", 1'b0, clkOutEn);
    regWr(ADDR_EVT_CTRL, 8'h56);
    chkRd("stampCount", ADDR_TS_COUNT, 8'h00);
    endTest("external");
    regWr(ADDR_CTRL_TWO, 8'h00);
    regWr(ADDR_EVT_CTRL, 8'h07);
    regWr(ADDR_CTRL_TWO, 8'h84);
    regWr(ADDR_NV_BACKUP, 8'h60);
    backup = 1'b1;
    waitClk(40);
    chkRd("status", ADDR_STATUS, 8'h00);
    backup = 1'b0;
    waitClk(DebSim + 50);
    regWr(ADDR_NV_BACKUP, 8'h64);
    cal = 48'h260615120030;
    backup = 1'b1;
    waitClk(40);
    chkBit("intN", 1'b0, intN);
    chkBit("clkOutEn", 1'b0, clkOutEn);
    chkRd("status", ADDR_STATUS, 8'h22);
    chkStamps(8'h01, cal);
    backup = 1'b0;
    waitClk(2);
    h.busStart();
    sendB({Slv, 1'b0});
    chkBit("debounceAck", 1'b1, lastAck);
    h.busStop();
    waitClk(DebSim);
    chkBit("clkOutEn", 1'b1, clkOutEn);
    regWr(ADDR_STATUS, 8'h00);
    waitClk(4);
    chkBit("intN", 1'b1, intN);
    endTest("switchover");
    // Source back to the pin while enabled, low level active and pin low
    regWr(ADDR_EVT_CTRL, 8'h02);
    waitClk(4);
    chkBit("intN", 1'b0, intN);
    chkRd("status", ADDR_STATUS, 8'h02);
    endTest("swap");
    stop_test();
  end
endmodule
`default_nettype wire
